// ==== shared/tsf_pkg.sv ====
// Purpose: constants and types shared by the two-slot fetch/execute core
// Assumes: one clock, six-bit character codes, word memory outside the core
// Notes: digits code as 00..09, minus as 0A, letters A..Z as 10..29
// Operation
// (RULE_01) every word and one-word register is twelve characters from a 63-symbol set
// (RULE_02) characters one and two select the order, four to six the cell
// (RULE_03) next-word pointer keeps the next word address in its three rightmost characters
// (RULE_04) first stage copies pointer's rightmost six characters into the instruction register
// (RULE_05) second stage reads the addressed word into the held-pair register
// (RULE_06) second stage also increments the next-word pointer by one
// (RULE_07) third stage moves the left half in and executes it
// (RULE_08) fourth stage moves the right half in, executes it, then cycle restarts
// (RULE_09) only the instruction register is executed, only in stages three and four
// (RULE_10) third character ignored; orders not needing character two accept zero there
// (RULE_11) bring copies cell m into accumulator and operand register; cell unchanged
// (RULE_12) load-compare copies cell m into compare and operand registers
// (RULE_13) store writes accumulator to cell m, then clears accumulator to zeros
// (RULE_14) add loads operand from cell m, accumulator becomes accumulator plus operand
// (RULE_15) leftmost character is the sign: zero plus, minus negative
// (RULE_16) an alphabetic character in either addend passes unchanged into the sum
// (RULE_17) skip order changes nothing and ignores its address
// (RULE_18) stop order halts execution and leaves all state unchanged
// (RULE_19) jump replaces only the pointer's three rightmost characters with its address
// (RULE_20) conditional jump jumps when accumulator equals compare word, else skips
// (RULE_21) programs put jump orders only in the right-hand slot
// (RULE_22) operator starts at the first stage with the pointer holding the start address
// (RULE_23) characters are six-bit codes; unknown orders behave as skips
package tsf_pkg;
  localparam int CW = 6;
  localparam int NCH = 12;
  localparam int WW = CW * NCH;
  localparam int HW = WW / 2;
  localparam int AW = 10;

  typedef logic [CW-1:0] tsf_char_t;
  typedef logic [WW-1:0] tsf_word_t;
  typedef logic [HW-1:0] tsf_half_t;
  typedef logic [AW-1:0] tsf_addr_t;
  typedef logic [3*CW-1:0] tsf_cell_t;

  // character codes
  localparam tsf_char_t CH_ZERO = 6'h00;
  localparam tsf_char_t CH_NINE = 6'h09;
  localparam tsf_char_t CH_MINUS = 6'h0A;
  localparam tsf_char_t CH_A = 6'h10;
  localparam tsf_char_t CH_B = 6'h11;
  localparam tsf_char_t CH_C = 6'h12;
  localparam tsf_char_t CH_L = 6'h1B;
  localparam tsf_char_t CH_Q = 6'h20;
  localparam tsf_char_t CH_U = 6'h24;

  // field positions inside a half word, sign position inside a word (lsb of each field)
  localparam int POS_OP1 = 30;
  localparam int POS_OP2 = 24;
  localparam int POS_CELL = 0;
  localparam int POS_SIGN = WW - CW;

  // values after reset and constants of the adder
  localparam tsf_word_t RST_WORD = 72'h0;
  localparam tsf_half_t RST_HALF = 36'h0;
  localparam tsf_word_t WORD_ONE = 72'h1;

  typedef enum logic [2:0] {
    ST_HALT = 3'b000,
    ST_ALPHA = 3'b001,
    ST_BETA = 3'b010,
    ST_GAMMA = 3'b011,
    ST_DELTA = 3'b100
  } tsf_stage_t;

  typedef enum logic [2:0] {
    OP_SKIP = 3'b000,
    OP_BRING = 3'b001,
    OP_LOADC = 3'b010,
    OP_STORE = 3'b011,
    OP_ADD = 3'b100,
    OP_STOP = 3'b101,
    OP_JUMP = 3'b110,
    OP_JEQ = 3'b111
  } tsf_order_t;

  typedef struct packed {
    logic req;
    logic we;
    tsf_addr_t addr;
    tsf_word_t wdata;
  } tsf_mem_cmd_t;
endpackage

// ==== hw/tsf_core.sv ====
// Purpose: four-stage fetch/execute sequencer for two orders per word
// Assumes: memory answers each request with mem_ack, read data valid with it
// Notes: ce low freezes every flip-flop and withdraws the memory request
module tsf_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire tsf_pkg::tsf_cell_t start_cell,
  output tsf_pkg::tsf_mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire tsf_pkg::tsf_word_t mem_rdata,
  output tsf_pkg::tsf_word_t next_word_pointer,
  output tsf_pkg::tsf_word_t held_pair_register,
  output tsf_pkg::tsf_half_t active_instruction_register,
  output tsf_pkg::tsf_word_t accumulator_word,
  output tsf_pkg::tsf_word_t compare_word,
  output tsf_pkg::tsf_word_t operand_word,
  output tsf_pkg::tsf_stage_t stage,
  output logic halted
);
  import tsf_pkg::*;

  // ----------------------------------------
  // character helpers
  // ----------------------------------------
  function automatic logic is_alpha(input tsf_char_t c);
    is_alpha = (c > CH_NINE);
  endfunction

  function automatic logic [3:0] digit(input tsf_char_t c);
    digit = is_alpha(c) ? 4'h0 : c[3:0];
  endfunction

  // (RULE_02) cell field to word index
  function automatic tsf_addr_t to_index(input tsf_cell_t a);
    tsf_addr_t h;
    tsf_addr_t t;
    tsf_addr_t u;
    h = {6'h00, digit(a[17:12])};
    t = {6'h00, digit(a[11:6])};
    u = {6'h00, digit(a[5:0])};
    to_index = AW'(h * 10'h064 + t * 10'h00A + u);
  endfunction

  // decimal magnitude add or subtract over the eleven digit positions;
  // top bit is the final carry or borrow
  function automatic logic [WW-CW:0] mag_op(input tsf_word_t a, input tsf_word_t b,
                                            input logic sub);
    logic [WW-CW:0] r;
    logic cy;
    tsf_char_t ca;
    tsf_char_t cb;
    logic [4:0] s;
    r = '0;
    cy = 1'b0;
    for (int i = 0; i < NCH - 1; i++) begin
      ca = a[CW*i +: CW];
      cb = b[CW*i +: CW];
      s = 5'h00;
      // (RULE_16) letters pass through
      if (is_alpha(ca)) begin
        r[CW*i +: CW] = ca;
        cy = 1'b0;
      end else if (is_alpha(cb)) begin
        r[CW*i +: CW] = cb;
        cy = 1'b0;
      end else if (!sub) begin
        s = {1'b0, ca[3:0]} + {1'b0, cb[3:0]} + {4'h0, cy};
        cy = (s > 5'h09);
        if (cy) begin
          s = s - 5'h0A;
        end
        r[CW*i +: CW] = {2'b00, s[3:0]};
      end else begin
        s = {1'b0, ca[3:0]} - {1'b0, cb[3:0]} - {4'h0, cy};
        cy = s[4];
        if (cy) begin
          s = s + 5'h0A;
        end
        r[CW*i +: CW] = {2'b00, s[3:0]};
      end
    end
    r[WW-CW] = cy;
    mag_op = r;
  endfunction

  // (RULE_15) signed add, sign in the leftmost character
  function automatic tsf_word_t alg_add(input tsf_word_t a, input tsf_word_t b);
    logic na;
    logic nb;
    logic [WW-CW:0] m1;
    logic [WW-CW:0] m2;
    na = (a[POS_SIGN +: CW] == CH_MINUS);
    nb = (b[POS_SIGN +: CW] == CH_MINUS);
    m1 = mag_op(a, b, na != nb);
    m2 = mag_op(b, a, 1'b1);
    if (na == nb || !m1[WW-CW]) begin
      alg_add = {na ? CH_MINUS : CH_ZERO, m1[WW-CW-1:0]};
    end else begin
      alg_add = {nb ? CH_MINUS : CH_ZERO, m2[WW-CW-1:0]};
    end
  endfunction

  // (RULE_23) unknown codes fall to skip so the stages never stall
  function automatic tsf_order_t decode(input tsf_half_t h);
    tsf_char_t o1;
    tsf_char_t o2;
    o1 = h[POS_OP1 +: CW];
    o2 = h[POS_OP2 +: CW];
    // (RULE_10) second character unused except by skip
    if (o1 == CH_B) begin
      decode = OP_BRING;
    end else if (o1 == CH_L) begin
      decode = OP_LOADC;
    end else if (o1 == CH_C) begin
      decode = OP_STORE;
    end else if (o1 == CH_A) begin
      decode = OP_ADD;
    end else if (o1 == CH_NINE) begin
      decode = OP_STOP;
    end else if (o1 == CH_U) begin
      decode = OP_JUMP;
    end else if (o1 == CH_Q) begin
      decode = OP_JEQ;
    end else begin
      decode = (o1 == CH_ZERO && o2 == CH_ZERO) ? OP_SKIP : OP_SKIP;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  tsf_stage_t stage_reg;
  tsf_stage_t stage_next;
  tsf_word_t cc_reg;
  tsf_word_t cc_next;
  tsf_word_t cr_reg;
  tsf_word_t cr_next;
  tsf_half_t sr_reg;
  tsf_half_t sr_next;
  tsf_word_t acc_reg;
  tsf_word_t acc_next;
  tsf_word_t cmp_reg;
  tsf_word_t cmp_next;
  tsf_word_t opr_reg;
  tsf_word_t opr_next;
  tsf_order_t order;
  logic exec;
  logic uses_mem;
  logic done;
  logic [WW-CW:0] cc_inc;

  // (RULE_09) only the instruction register is decoded, only when executing
  assign order = decode(sr_reg);
  assign exec = (stage_reg == ST_GAMMA) || (stage_reg == ST_DELTA);
  assign uses_mem = (order == OP_BRING) || (order == OP_LOADC) ||
                    (order == OP_STORE) || (order == OP_ADD);
  assign done = !uses_mem || mem_ack;
  // adder result kept in its own net: a select straight on a call is not portable
  assign cc_inc = mag_op(cc_reg, WORD_ONE, 1'b0);

  // (RULE_05) memory address always from the instruction register cell field
  assign mem_cmd.req = ce && ((stage_reg == ST_BETA) || (exec && uses_mem));
  assign mem_cmd.we = exec && (order == OP_STORE);
  assign mem_cmd.addr = to_index(sr_reg[POS_CELL +: 3*CW]);
  assign mem_cmd.wdata = acc_reg;

  always_comb begin
    stage_next = stage_reg;
    cc_next = cc_reg;
    cr_next = cr_reg;
    sr_next = sr_reg;
    acc_next = acc_reg;
    cmp_next = cmp_reg;
    opr_next = opr_reg;
    unique case (stage_reg)
      ST_HALT: begin
        // (RULE_22) start loads the pointer and enters the first stage
        if (start) begin
          cc_next = {RST_WORD[WW-1:3*CW], start_cell};
          stage_next = ST_ALPHA;
        end
      end
      ST_ALPHA: begin
        // (RULE_04) pointer half into instruction register
        sr_next = cc_reg[HW-1:0];
        stage_next = ST_BETA;
      end
      ST_BETA: begin
        if (mem_ack) begin
          // (RULE_05) word into held pair
          cr_next = mem_rdata;
          // (RULE_06) pointer plus one
          cc_next = {cc_reg[POS_SIGN +: CW], cc_inc[WW-CW-1:0]};
          // (RULE_07) left half moves in for the third stage
          sr_next = mem_rdata[WW-1:HW];
          stage_next = ST_GAMMA;
        end
      end
      ST_GAMMA, ST_DELTA: begin
        if (done) begin
          unique case (order)
            // (RULE_11) bring
            OP_BRING: begin
              acc_next = mem_rdata;
              opr_next = mem_rdata;
            end
            // (RULE_12) load compare
            OP_LOADC: begin
              cmp_next = mem_rdata;
              opr_next = mem_rdata;
            end
            // (RULE_13) store then clear
            OP_STORE: begin
              acc_next = RST_WORD;
            end
            // (RULE_14) operand load and add
            OP_ADD: begin
              opr_next = mem_rdata;
              acc_next = alg_add(acc_reg, mem_rdata);
            end
            // (RULE_19) jump on cell field
            OP_JUMP: begin
              cc_next = {cc_reg[WW-1:3*CW], sr_reg[POS_CELL +: 3*CW]};
            end
            // (RULE_20) jump on equal
            OP_JEQ: begin
              if (acc_reg == cmp_reg) begin
                cc_next = {cc_reg[WW-1:3*CW], sr_reg[POS_CELL +: 3*CW]};
              end
            end
            // (RULE_17) skip leaves everything
            OP_SKIP: begin
            end
            OP_STOP: begin
            end
          endcase
          // (RULE_18) stop halts with state untouched
          if (order == OP_STOP) begin
            stage_next = ST_HALT;
          end else if (stage_reg == ST_GAMMA) begin
            // (RULE_08) right half moves in
            sr_next = cr_reg[HW-1:0];
            stage_next = ST_DELTA;
          end else begin
            stage_next = ST_ALPHA;
          end
        end
      end
      default: begin
        stage_next = ST_HALT;
      end
    endcase
  end

  // (RULE_01) twelve six-bit characters per word register, six in the instruction register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_reg <= ST_HALT;
      cc_reg <= RST_WORD;
      cr_reg <= RST_WORD;
      sr_reg <= RST_HALF;
      acc_reg <= RST_WORD;
      cmp_reg <= RST_WORD;
      opr_reg <= RST_WORD;
    end else if (ce) begin
      stage_reg <= stage_next;
      cc_reg <= cc_next;
      cr_reg <= cr_next;
      sr_reg <= sr_next;
      acc_reg <= acc_next;
      cmp_reg <= cmp_next;
      opr_reg <= opr_next;
    end
  end

  // ----------------------------------------
  // observation outputs
  // ----------------------------------------
  // (RULE_03) pointer cell lives in the rightmost three characters
  assign next_word_pointer = cc_reg;
  assign held_pair_register = cr_reg;
  assign active_instruction_register = sr_reg;
  assign accumulator_word = acc_reg;
  assign compare_word = cmp_reg;
  assign operand_word = opr_reg;
  assign stage = stage_reg;
  assign halted = (stage_reg == ST_HALT);
endmodule

// ==== bench/tsf_mem_model.sv ====
// Purpose: behavioural word memory facing the fetch/execute core
// Assumes: the bench preloads cells and sets lat between programs
// Notes: lat is the number of wait cycles before mem_ack
module tsf_mem_model (
  input wire logic mclk,
  input wire tsf_pkg::tsf_mem_cmd_t mem_cmd,
  output logic mem_ack,
  output tsf_pkg::tsf_word_t mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import tsf_pkg::*;
  // ---------------------------------
  // storage and handshake
  // ---------------------------------
  // twelve-character words
  tsf_word_t cells [1000];
  int lat = 0;
  int cnt = 0;
  assign mem_ack = mem_cmd.req && cnt >= lat;
  // data flips outside an answer so stale words never pass for good ones
  assign mem_rdata = mem_ack ? cells[mem_cmd.addr] : ~cells[mem_cmd.addr];
  always @(posedge mclk) begin
    // count holds while a clock-enable gap withdraws the request, else long waits never end
    cnt <= mem_ack ? 0 : (mem_cmd.req ? cnt + 1 : cnt);
    if (mem_ack && mem_cmd.we) cells[mem_cmd.addr] <= mem_cmd.wdata;
  end
endmodule

// ==== bench/tsf_core_asserts.sv ====
// Purpose: concurrent checks on the two-slot fetch/execute core
// Assumes: memory data valid in the cycle of mem_ack
// Notes: address checks assume digit-only address characters
module tsf_core_asserts
  import tsf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire tsf_cell_t start_cell,
  input wire tsf_mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire tsf_word_t mem_rdata,
  input wire tsf_word_t next_word_pointer,
  input wire tsf_word_t held_pair_register,
  input wire tsf_half_t active_instruction_register,
  input wire tsf_word_t accumulator_word,
  input wire tsf_word_t compare_word,
  input wire tsf_word_t operand_word,
  input wire tsf_stage_t stage,
  input wire logic halted
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------
  // helpers and checks
  // ---------------------------------
  wire tsf_char_t op = active_instruction_register[35:30];
  wire logic ex = ce && (stage == ST_GAMMA || stage == ST_DELTA);
  wire logic rd = ex && mem_ack && !mem_cmd.we;
  function automatic int dec(tsf_cell_t c);
    return c[17:12] * 100 + c[11:6] * 10 + c[5:0];
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  alpha_copy_a: assert property (stage == ST_ALPHA && ce |=> stage == ST_BETA &&
    active_instruction_register == $past(next_word_pointer[35:0])) else $error("alpha copy");
  beta_addr_a: assert property (stage == ST_BETA && mem_cmd.req |-> !mem_cmd.we &&
    mem_cmd.addr == tsf_addr_t'(dec(active_instruction_register[17:0]))) else $error("fetch addr");
  beta_load_a: assert property (stage == ST_BETA && ce && mem_ack |=> stage == ST_GAMMA &&
    held_pair_register == $past(mem_rdata) &&
    active_instruction_register == $past(mem_rdata[71:36])) else $error("fetch load");
  beta_incr_a: assert property (stage == ST_BETA && ce && mem_ack |=>
    dec(next_word_pointer[17:0]) == (dec($past(next_word_pointer[17:0])) + 1) % 1000)
    else $error("pointer step");
  delta_right_a: assert property (stage == ST_GAMMA ##1 stage == ST_DELTA |->
    active_instruction_register == held_pair_register[35:0]) else $error("right half");
  delta_wrap_a: assert property (stage == ST_DELTA && ce && !mem_cmd.req &&
    op != CH_NINE |=> stage == ST_ALPHA) else $error("cycle restart");
  bring_a: assert property (rd && op == CH_B |=> accumulator_word == $past(mem_rdata) &&
    operand_word == $past(mem_rdata)) else $error("bring");
  loadc_a: assert property (rd && op == CH_L |=> compare_word == $past(mem_rdata) &&
    operand_word == $past(mem_rdata)) else $error("load compare");
  store_clear_a: assert property (ex && mem_ack && mem_cmd.we |-> op == CH_C &&
    mem_cmd.wdata == accumulator_word ##1 accumulator_word == RST_WORD) else $error("store");
  jump_a: assert property (stage == ST_DELTA && ce && op == CH_U |=>
    next_word_pointer == {$past(next_word_pointer[71:18]),
    $past(active_instruction_register[17:0])}) else $error("jump");
  stop_hold_a: assert property (ex && op == CH_NINE |=> halted &&
    $stable(next_word_pointer) && $stable(accumulator_word)) else $error("stop");
  skip_quiet_a: assert property (ex && op == CH_ZERO |-> !mem_cmd.req ##1
    $stable(accumulator_word)) else $error("skip");
  cover property (ex && op == CH_U);
  cover property (ex && mem_ack && mem_cmd.we);
  cover property (rd && op == CH_L);
endmodule
bind tsf_core tsf_core_asserts u_chk (.*);

// ==== bench/tsf_core_tb.sv ====
// Purpose: self-checking bench for the two-slot fetch/execute core
// Assumes: programs are preloaded into the memory model cell array
// Notes: every program starts at cell 000; all but the reset test's endless loop end on a stop order
module tsf_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsf_pkg::*;
  // ---------------------------------
  // signals, helpers, scenarios
  // ---------------------------------
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
  logic mclk, rst, ce, start, mem_ack, halted;
  tsf_cell_t start_cell;
  tsf_mem_cmd_t mem_cmd;
  tsf_word_t mem_rdata, next_word_pointer, held_pair_register;
  tsf_word_t accumulator_word, compare_word, operand_word;
  tsf_half_t active_instruction_register;
  tsf_stage_t stage;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  tsf_core dut (.*);
  tsf_mem_model mem (.*);
  function automatic tsf_word_t w(string s);
    tsf_word_t r;
    r = RST_WORD;
    for (int i = 0; i < 12; i++) begin
      r = r << CW;
      if (s[i] == "-") r[5:0] = CH_MINUS;
      else if (s[i] >= "A") r[5:0] = 6'(s[i] - "A" + 16);
      else r[5:0] = 6'(s[i] - "0");
    end
    return r;
  endfunction
  task automatic ld(int a, string s);
    mem.cells[a] = w(s);
  endtask
  task automatic clr;
    for (int i = 0; i < 1000; i++) mem.cells[i] = RST_WORD;
  endtask
  task automatic go;
    @(negedge mclk);
    start = 1'b1;
    start_cell = 18'h0;
    @(negedge mclk);
    start = 1'b0;
  endtask
  task automatic run(int lat, bit gaps);
    int k;
    k = 0;
    mem.lat = lat;
    go;
    while (halted !== 1'b1 && k < 500) begin
      ce = !(gaps && k % 3 == 0);
      @(negedge mclk);
      k++;
    end
    ce = 1'b1;
    `CHK("halted", 1'b1, halted)
  endtask
  task automatic t_swap;
    clr;
    ld(0, "B05100C00102");
    ld(1, "B00101C00100");
    ld(2, "B00102C00101");
    ld(3, "900000000000");
    ld(100, "ABCDEFG986KL");
    ld(101, "-00125000000");
    run(0, 1'b0);
    `CHK("cell100", w("-00125000000"), mem.cells[100])
    `CHK("cell101", w("ABCDEFG986KL"), mem.cells[101])
    `CHK("acc", RST_WORD, accumulator_word)
    `CHK("ptr", w("000000000004"), next_word_pointer)
  endtask
  task automatic t_add;
    clr;
    ld(0, "B00100A00101");
    ld(1, "C00102B00103");
    ld(2, "A00104900000");
    ld(100, "000000000030");
    ld(101, "-00000000100");
    ld(103, "012456014892");
    ld(104, "032A69CZ154G");
    run(3, 1'b1);
    `CHK("cell102", w("-00000000070"), mem.cells[102])
    `CHK("acc", w("044A25CZ643G"), accumulator_word)
    `CHK("opr", w("032A69CZ154G"), operand_word)
    `CHK("ptr", w("000000000003"), next_word_pointer)
  endtask
  task automatic t_jump(bit eq);
    clr;
    ld(0, "L00100U00005");
    ld(5, "B00101Q00009");
    ld(6, "000123900000");
    ld(9, "Z00555900000");
    ld(100, "000000000042");
    ld(101, eq ? "000000000042" : "000000000043");
    run(1, 1'b0);
    `CHK("cmp", w("000000000042"), compare_word)
    `CHK("acc", mem.cells[101], accumulator_word)
    `CHK("ptr", w(eq ? "000000000010" : "000000000007"), next_word_pointer)
  endtask
  task automatic t_rst;
    clr;
    ld(0, "B00100U00000");
    ld(100, "000000000077");
    mem.lat = 0;
    go;
    repeat (9) @(negedge mclk);
    `CHK("loop", w("000000000077"), accumulator_word)
    rst = 1'b1;
    @(negedge mclk);
    `CHK("stage", ST_HALT, stage)
    `CHK("acc", RST_WORD, accumulator_word)
    `CHK("ptr", RST_WORD, next_word_pointer)
    rst = 1'b0;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard: runs need far fewer cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    start_cell = 18'h0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_swap;
    t_add;
    t_jump(1'b1);
    t_jump(1'b0);
    t_rst;
    t_swap;
    wrap_up;
  end
endmodule
